// >>> hdl/abx_map.svh
`ifndef ABX_MAP_SVH
`define ABX_MAP_SVH
`define ABX_FLAG_C 0
`define ABX_FLAG_Z 1
`define ABX_FLAG_N 2
`define ABX_FLAG_V 3
`define ABX_FLAG_S 4
`define ABX_FLAG_H 5
`define ABX_SREG_RST 8'h00
`define ABX_PC_RST 16'h0000
`define ABX_CYC_ONE 2'h1
`define ABX_CYC_TWO 2'h2
`define ABX_CYC_THREE 2'h3
`define ABX_BYTE_ONES 8'hFF
`define ABX_PROD_PAIR 5'h00
`define ABX_STEP 16'h0001
`define ABX_SKIP_SHORT 16'h0002
`define ABX_SKIP_LONG 16'h0003
`define ABX_WORD_K_W 6
`endif

// >>> hdl/abx_pkg.sv
package abx_pkg;
    typedef enum logic [4:0] {
        OP_CARRY_SUM_REGS, OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM, OP_DIFF_IMM,
        OP_BORROW_DIFF_REGS, OP_BORROW_DIFF_IMM, OP_CONJ_REGS, OP_CONJ_IMM,
        OP_DISJ_REGS, OP_DISJ_IMM, OP_XDISJ_REGS, OP_SET_BITS_IMM,
        OP_CLEAR_BITS_IMM, OP_ZERO_SIGN_CHECK, OP_PROD_UU, OP_PROD_SS,
        OP_PROD_SU, OP_FRAC_UU, OP_FRAC_SS, OP_FRAC_SU, OP_INDIRECT_JUMP,
        OP_INDIRECT_INVOKE, OP_EQUAL_SKIP, OP_COMPARE_REGS,
        OP_CARRY_COMPARE_REGS, OP_COMPARE_IMM, OP_REG_BIT_CLR_SKIP,
        OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLR_SKIP, OP_IO_BIT_SET_SKIP
    } abx_op_e;

    typedef enum {ST_IDLE, ST_BUSY} abx_state_e;

    typedef struct packed {
        abx_op_e     op;
        logic [4:0]  d_addr;
        logic [7:0]  d_val;
        logic [7:0]  d_hi;
        logic [7:0]  r_val;
        logic [7:0]  imm;
        logic [2:0]  bit_sel;
        logic [7:0]  io_val;
        logic [15:0] pc;
        logic [15:0] z_ptr;
        logic [7:0]  sreg;
        logic        next_two_word;
    } abx_req_s;

    typedef struct packed {
        logic        wr_en;
        logic        wr_pair;
        logic [4:0]  wr_addr;
        logic [15:0] wr_data;
        logic [7:0]  sreg;
        logic [15:0] next_pc;
        logic        pc_load;
        logic        ret_push;
        logic [15:0] ret_addr;
    } abx_res_s;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       h;
        logic       v;
    } abx_alu_s;
endpackage

// >>> hdl/abx_exec_unit.sv
`include "abx_map.svh"

module abx_exec_unit
    import abx_pkg::*;
#(
    parameter int K_W = `ABX_WORD_K_W
) (
    input  wire logic     clk,
    input  wire logic     rst_b,
    input  wire logic     req_valid,
    output logic          req_ready,
    input  wire abx_req_s req,
    output logic          done,
    output abx_res_s      res
);

    // ****************************************************************
    // Parameter check.
    // ****************************************************************
    if (K_W < 1 || K_W > 8) begin : g_bad_k
        $error("Word immediate width must lie between 1 and 8.");
    end

    // ****************************************************************
    // Arithmetic helpers.
    // ****************************************************************
    function automatic abx_alu_s add_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin, input logic sub);
        logic [8:0] full;
        logic [4:0] half;
        abx_alu_s   o;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        end
        o.res = full[7:0];
        o.c   = full[8];
        o.h   = half[4];
        o.v   = sub ? ((a[7] ^ b[7]) & (a[7] ^ full[7]))
                    : (~(a[7] ^ b[7]) & (a[7] ^ full[7]));
        return o;
    endfunction

    function automatic logic [7:0] arith_flags(input logic [7:0] s, input abx_alu_s o);
        logic [7:0] f;
        f = s;
        f[`ABX_FLAG_Z] = (o.res == 8'h00);
        f[`ABX_FLAG_C] = o.c;
        f[`ABX_FLAG_N] = o.res[7];
        f[`ABX_FLAG_V] = o.v;
        f[`ABX_FLAG_H] = o.h;
        return f;
    endfunction

    function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r);
        logic [7:0] f;
        f = s;
        f[`ABX_FLAG_Z] = (r == 8'h00);
        f[`ABX_FLAG_N] = r[7];
        f[`ABX_FLAG_V] = 1'b0;
        return f;
    endfunction

    function automatic logic [15:0] product(input logic [7:0] a, input logic [7:0] b,
                                            input logic sa, input logic sb);
        logic signed [17:0] p;
        p = $signed({sa & a[7], a}) * $signed({sb & b[7], b});
        return p[15:0];
    endfunction

    // ****************************************************************
    // Operation decode and result.
    // ****************************************************************
    abx_state_e  state_q;
    logic [1:0]  cnt_q;
    logic        done_q;
    abx_res_s    res_q;
    abx_res_s    res_d;
    logic [1:0]  cyc_d;
    abx_alu_s    alu;
    logic [7:0]  lres;
    logic [15:0] prod;
    logic [15:0] pres;
    logic [15:0] wsum;
    logic [15:0] wk;
    logic        skip;
    logic        cin;
    logic        accept;

    assign cin    = req.sreg[`ABX_FLAG_C];
    assign wk     = 16'(req.imm[K_W-1:0]);
    assign accept = req_valid && req_ready;

    always_comb begin
        alu   = '0;
        lres  = 8'h00;
        prod  = 16'h0000;
        pres  = 16'h0000;
        wsum  = 16'h0000;
        skip  = 1'b0;
        cyc_d = `ABX_CYC_ONE;
        res_d = '0;
        res_d.sreg    = req.sreg;
        res_d.wr_addr = req.d_addr;
        res_d.next_pc = req.pc + `ABX_STEP;
        case (req.op)
            OP_CARRY_SUM_REGS, OP_DIFF_IMM, OP_BORROW_DIFF_REGS, OP_BORROW_DIFF_IMM,
            OP_COMPARE_REGS, OP_CARRY_COMPARE_REGS, OP_COMPARE_IMM: begin
                case (req.op)
                    OP_CARRY_SUM_REGS:     alu = add_sub(req.d_val, req.r_val, cin, 1'b0);
                    OP_DIFF_IMM:           alu = add_sub(req.d_val, req.imm, 1'b0, 1'b1);
                    OP_BORROW_DIFF_REGS:   alu = add_sub(req.d_val, req.r_val, cin, 1'b1);
                    OP_BORROW_DIFF_IMM:    alu = add_sub(req.d_val, req.imm, cin, 1'b1);
                    OP_COMPARE_REGS:       alu = add_sub(req.d_val, req.r_val, 1'b0, 1'b1);
                    OP_CARRY_COMPARE_REGS: alu = add_sub(req.d_val, req.r_val, cin, 1'b1);
                    default:               alu = add_sub(req.d_val, req.imm, 1'b0, 1'b1);
                endcase
                res_d.sreg    = arith_flags(req.sreg, alu);
                res_d.wr_data = {8'h00, alu.res};
                res_d.wr_en   = !(req.op inside {OP_COMPARE_REGS, OP_CARRY_COMPARE_REGS,
                                                 OP_COMPARE_IMM});
            end
            OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
                if (req.op == OP_WORD_PLUS_IMM) begin
                    wsum = {req.d_hi, req.d_val} + wk;
                    res_d.sreg[`ABX_FLAG_V] = ~req.d_hi[7] & wsum[15];
                    res_d.sreg[`ABX_FLAG_C] = ~wsum[15] & req.d_hi[7];
                end else begin
                    wsum = {req.d_hi, req.d_val} - wk;
                    res_d.sreg[`ABX_FLAG_V] = req.d_hi[7] & ~wsum[15];
                    res_d.sreg[`ABX_FLAG_C] = wsum[15] & ~req.d_hi[7];
                end
                res_d.sreg[`ABX_FLAG_Z] = (wsum == 16'h0000);
                res_d.sreg[`ABX_FLAG_N] = wsum[15];
                res_d.sreg[`ABX_FLAG_S] = wsum[15] ^ res_d.sreg[`ABX_FLAG_V];
                res_d.wr_en   = 1'b1;
                res_d.wr_pair = 1'b1;
                res_d.wr_data = wsum;
                cyc_d         = `ABX_CYC_TWO;
            end
            OP_CONJ_REGS, OP_CONJ_IMM, OP_DISJ_REGS, OP_DISJ_IMM, OP_XDISJ_REGS,
            OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_ZERO_SIGN_CHECK: begin
                case (req.op)
                    OP_CONJ_REGS:      lres = req.d_val & req.r_val;
                    OP_CONJ_IMM:       lres = req.d_val & req.imm;
                    OP_DISJ_REGS:      lres = req.d_val | req.r_val;
                    OP_DISJ_IMM:       lres = req.d_val | req.imm;
                    OP_XDISJ_REGS:     lres = req.d_val ^ req.r_val;
                    OP_SET_BITS_IMM:   lres = req.d_val | req.imm;
                    OP_CLEAR_BITS_IMM: lres = req.d_val & (`ABX_BYTE_ONES - req.imm);
                    default:           lres = req.d_val & req.d_val;
                endcase
                res_d.sreg    = logic_flags(req.sreg, lres);
                res_d.wr_en   = 1'b1;
                res_d.wr_data = {8'h00, lres};
            end
            OP_PROD_UU, OP_PROD_SS, OP_PROD_SU, OP_FRAC_UU, OP_FRAC_SS, OP_FRAC_SU: begin
                prod = product(req.d_val, req.r_val,
                               !(req.op inside {OP_PROD_UU, OP_FRAC_UU}),
                               req.op inside {OP_PROD_SS, OP_FRAC_SS});
                pres = (req.op inside {OP_FRAC_UU, OP_FRAC_SS, OP_FRAC_SU})
                     ? {prod[14:0], 1'b0} : prod;
                res_d.sreg[`ABX_FLAG_C] = prod[15];
                res_d.sreg[`ABX_FLAG_Z] = (pres == 16'h0000);
                res_d.wr_en   = 1'b1;
                res_d.wr_pair = 1'b1;
                res_d.wr_addr = `ABX_PROD_PAIR;
                res_d.wr_data = pres;
                cyc_d         = `ABX_CYC_TWO;
            end
            OP_INDIRECT_JUMP: begin
                res_d.next_pc = req.z_ptr;
                res_d.pc_load = 1'b1;
                cyc_d         = `ABX_CYC_TWO;
            end
            OP_INDIRECT_INVOKE: begin
                res_d.ret_push = 1'b1;
                res_d.ret_addr = req.pc + `ABX_STEP;
                res_d.next_pc  = req.z_ptr;
                res_d.pc_load  = 1'b1;
                cyc_d          = `ABX_CYC_THREE;
            end
            OP_EQUAL_SKIP, OP_REG_BIT_CLR_SKIP, OP_REG_BIT_SET_SKIP,
            OP_IO_BIT_CLR_SKIP, OP_IO_BIT_SET_SKIP: begin
                case (req.op)
                    OP_EQUAL_SKIP:       skip = (req.d_val == req.r_val);
                    OP_REG_BIT_CLR_SKIP: skip = !req.r_val[req.bit_sel];
                    OP_REG_BIT_SET_SKIP: skip = req.r_val[req.bit_sel];
                    OP_IO_BIT_CLR_SKIP:  skip = !req.io_val[req.bit_sel];
                    default:             skip = req.io_val[req.bit_sel];
                endcase
                if (skip) begin
                    res_d.next_pc = req.pc + (req.next_two_word ? `ABX_SKIP_LONG
                                                                : `ABX_SKIP_SHORT);
                    cyc_d = req.next_two_word ? `ABX_CYC_THREE : `ABX_CYC_TWO;
                end
            end
            default: begin
                res_d.sreg = req.sreg;
            end
        endcase
    end

    // ****************************************************************
    // Cycle sequencing.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q   <= 2'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept && cyc_d != `ABX_CYC_ONE) begin
                        state_q <= ST_BUSY;
                        cnt_q   <= cyc_d - `ABX_CYC_ONE;
                    end
                end
                ST_BUSY: begin
                    cnt_q <= cnt_q - 2'h1;
                    if (cnt_q == 2'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (accept && cyc_d == `ABX_CYC_ONE) ||
                      (state_q == ST_BUSY && cnt_q == 2'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            res_q         <= '0;
            res_q.sreg    <= `ABX_SREG_RST;
            res_q.next_pc <= `ABX_PC_RST;
        end else if (accept) begin
            res_q <= res_d;
        end
    end

    assign req_ready = (state_q == ST_IDLE);
    assign done      = done_q;
    assign res       = res_q;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_carry_sum: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == OP_CARRY_SUM_REGS |=> done &&
        res.wr_data[7:0] == 8'($past(req.d_val) + $past(req.r_val) + $past(cin)))
        else $error("Carry sum result is wrong.");

    a_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op inside {OP_DIFF_IMM, OP_BORROW_DIFF_REGS, OP_CONJ_IMM,
        OP_COMPARE_IMM} |=> done && req_ready)
        else $error("Single cycle operation did not finish in one cycle.");

    a_two_cycle: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op inside {OP_PROD_UU, OP_FRAC_SU, OP_WORD_PLUS_IMM}
        |=> !done && !req_ready ##1 done && req_ready)
        else $error("Two cycle operation timing is wrong.");

    a_invoke_three: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == OP_INDIRECT_INVOKE |=> !done [*2] ##1
        (done && res.ret_push && res.next_pc == $past(req.z_ptr, 3)))
        else $error("Indirect invoke timing or target is wrong.");

    a_flow_flags: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op inside {OP_INDIRECT_JUMP, OP_EQUAL_SKIP, OP_IO_BIT_SET_SKIP}
        |=> res.sreg == $past(req.sreg) && !res.wr_en)
        else $error("Flow operation touched flags or registers.");

    a_skip_long: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == OP_REG_BIT_SET_SKIP && req.r_val[req.bit_sel] &&
        req.next_two_word |=> !done ##1 !done ##1
        (done && res.next_pc == $past(req.pc, 3) + `ABX_SKIP_LONG))
        else $error("Long skip advance or timing is wrong.");

    a_compare_nowr: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op inside {OP_COMPARE_REGS, OP_CARRY_COMPARE_REGS}
        |=> !res.wr_en && res.sreg[`ABX_FLAG_Z] == (8'($past(req.d_val) - $past(req.r_val)
        - {7'h00, $past(cin) && $past(req.op) == OP_CARRY_COMPARE_REGS}) == 8'h00))
        else $error("Compare wrote a register or set zero wrongly.");

    a_logic_vclr: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == OP_CLEAR_BITS_IMM |=> !res.sreg[`ABX_FLAG_V] &&
        res.wr_data[7:0] == ($past(req.d_val) & ~$past(req.imm)))
        else $error("Clear bits result or overflow flag is wrong.");

    a_prod_pair: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == OP_FRAC_UU |=> res.wr_pair && res.wr_addr == `ABX_PROD_PAIR
        && res.wr_data == 16'({8'h00, $past(req.d_val)} * {8'h00, $past(req.r_val)} << 1))
        else $error("Fractional product is wrong.");

endmodule // abx_exec_unit

// >>> sim/abx_fetch_model.sv
// ********************************
// Fetch side request source
// ********************************
module abx_fetch_model
    import abx_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic slow,
    input  wire logic req_ready,
    output abx_req_s  req,
    output logic      req_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    abx_req_s pend_q[$];
    logic     pop;

    task automatic push(input abx_req_s r);
        pend_q.push_back(r);
    endtask

    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // Holds a request until it is taken; an idle bus shows the inverse of its last value.
    always @(posedge clk) begin
        pop = req_valid && req_ready;
        if (pop) begin
            void'(pend_q.pop_front());
        end
        if (!rst_b) begin
            pend_q.delete();
        end
        if (rst_b && pend_q.size() > 0 && !(pop && slow)) begin
            req_valid <= 1'b1;
            req       <= pend_q[0];
        end else begin
            req_valid <= 1'b0;
            req       <= abx_req_s'(~req);
        end
    end
endmodule // abx_fetch_model

// >>> sim/tb_top.sv
`include "abx_map.svh"

module tb_top
    import abx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int KW = 6;

    typedef struct packed {
        logic [15:0] data;
        logic [15:0] npc;
        logic [15:0] ret;
        logic [7:0]  sreg;
        logic [4:0]  addr;
        logic [1:0]  cyc;
        logic [1:0]  grp;
        logic        wr;
        logic        wro;
        logic        pair;
        logic        load;
        logic        push;
    } abx_tb_exp_s;

    typedef struct packed {
        abx_req_s    req;
        abx_tb_exp_s exp;
    } abx_tb_row_s;

    logic        clk;
    logic        rst_b;
    logic        slow;
    logic        req_valid;
    logic        req_ready;
    logic        done;
    abx_req_s    req;
    abx_res_s    res;
    abx_tb_row_s rows[90];
    abx_req_s    base[3];
    abx_tb_exp_s exp_q[$];
    int          acc_q[$];
    int          mismatches;
    int          checked;
    int          cyc;
    abx_tb_exp_s e;
    logic [15:0] got;
    logic [7:0]  lat;
    logic [7:0]  cy;

    abx_exec_unit #(
        .K_W (KW)
    ) abx_exec_unit_inst (
        .clk       (clk),
        .rst_b     (rst_b),
        .req_valid (req_valid),
        .req_ready (req_ready),
        .req       (req),
        .done      (done),
        .res       (res)
    );

    abx_fetch_model abx_fetch_model_inst (
        .clk       (clk),
        .rst_b     (rst_b),
        .slow      (slow),
        .req_ready (req_ready),
        .req       (req),
        .req_valid (req_valid)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ********************************
    // Expected results
    // ********************************
    function automatic abx_tb_exp_s ref_of(input abx_req_s q);
        abx_tb_exp_s x;
        logic [7:0]  b;
        logic [7:0]  r8;
        logic [8:0]  s9;
        logic [4:0]  h5;
        logic [15:0] pa;
        logic [15:0] pb;
        logic        cin;
        logic        add;
        logic        tk;
        x = '0;
        x.sreg = q.sreg;
        x.cyc = `ABX_CYC_ONE;
        x.addr = q.d_addr;
        x.npc = q.pc + `ABX_STEP;
        x.ret = q.pc + `ABX_STEP;
        x.wr = 1'b1;
        add = q.op inside {OP_CARRY_SUM_REGS, OP_WORD_PLUS_IMM};
        cin = q.sreg[`ABX_FLAG_C] && (q.op inside {OP_CARRY_SUM_REGS, OP_BORROW_DIFF_REGS,
              OP_BORROW_DIFF_IMM, OP_CARRY_COMPARE_REGS});
        b = (q.op inside {OP_CARRY_SUM_REGS, OP_BORROW_DIFF_REGS, OP_CONJ_REGS, OP_DISJ_REGS,
            OP_XDISJ_REGS, OP_COMPARE_REGS, OP_CARRY_COMPARE_REGS}) ? q.r_val : q.imm;
        case (q.op)
            OP_CONJ_REGS, OP_CONJ_IMM: r8 = q.d_val & b;
            OP_DISJ_REGS, OP_DISJ_IMM, OP_SET_BITS_IMM: r8 = q.d_val | b;
            OP_XDISJ_REGS: r8 = q.d_val ^ b;
            OP_CLEAR_BITS_IMM: r8 = q.d_val & (`ABX_BYTE_ONES - b);
            default: r8 = q.d_val & q.d_val;
        endcase
        if (q.op inside {[OP_CONJ_REGS:OP_ZERO_SIGN_CHECK]}) begin
            x.grp = 2'h1;
            x.wro = (q.op == OP_ZERO_SIGN_CHECK);
        end else if (q.op inside {OP_CARRY_SUM_REGS, [OP_DIFF_IMM:OP_BORROW_DIFF_IMM],
                     [OP_COMPARE_REGS:OP_COMPARE_IMM]}) begin
            s9 = add ? 9'(q.d_val) + 9'(b) + 9'(cin) : 9'(q.d_val) - 9'(b) - 9'(cin);
            h5 = add ? 5'(q.d_val[3:0]) + 5'(b[3:0]) + 5'(cin)
                     : 5'(q.d_val[3:0]) - 5'(b[3:0]) - 5'(cin);
            r8 = s9[7:0];
            x.wr = !(q.op inside {[OP_COMPARE_REGS:OP_COMPARE_IMM]});
            x.sreg[`ABX_FLAG_C] = s9[8];
            x.sreg[`ABX_FLAG_H] = h5[4];
        end
        x.data = {8'h00, r8};
        x.sreg[`ABX_FLAG_V] = add ? (q.d_val[7] == b[7]) && (r8[7] != b[7])
                                  : (q.d_val[7] != b[7]) && (r8[7] == b[7]);
        x.sreg[`ABX_FLAG_V] = x.sreg[`ABX_FLAG_V] && (x.grp == 2'h0);
        x.sreg[`ABX_FLAG_N] = r8[7];
        x.sreg[`ABX_FLAG_Z] = (r8 == 8'h00);
        if (q.op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM}) begin
            x = ref_word(q, x, add);
        end else if (q.op inside {[OP_PROD_UU:OP_FRAC_SU]}) begin
            pa = (q.op inside {OP_PROD_UU, OP_FRAC_UU}) ? 16'(q.d_val) : 16'($signed(q.d_val));
            pb = (q.op inside {OP_PROD_SS, OP_FRAC_SS}) ? 16'($signed(q.r_val)) : 16'(q.r_val);
            pa = pa * pb;
            x.sreg = q.sreg;
            x.grp = 2'h2;
            x.cyc = `ABX_CYC_TWO;
            x.pair = 1'b1;
            x.addr = `ABX_PROD_PAIR;
            x.sreg[`ABX_FLAG_C] = pa[15];
            x.data = (q.op inside {[OP_FRAC_UU:OP_FRAC_SU]}) ? pa << 1 : pa;
            x.sreg[`ABX_FLAG_Z] = (x.data == 16'h0000);
        end else if (q.op inside {OP_INDIRECT_JUMP, OP_INDIRECT_INVOKE, OP_EQUAL_SKIP,
                     [OP_REG_BIT_CLR_SKIP:OP_IO_BIT_SET_SKIP]}) begin
            tk = (q.op == OP_EQUAL_SKIP) ? q.d_val == q.r_val :
                 (q.op == OP_REG_BIT_CLR_SKIP) ? !q.r_val[q.bit_sel] :
                 (q.op == OP_REG_BIT_SET_SKIP) ? q.r_val[q.bit_sel] :
                 (q.op == OP_IO_BIT_CLR_SKIP) ? !q.io_val[q.bit_sel] : q.io_val[q.bit_sel];
            x.sreg = q.sreg;
            x.grp = 2'h3;
            x.wr = 1'b0;
            x.load = q.op inside {OP_INDIRECT_JUMP, OP_INDIRECT_INVOKE};
            x.push = (q.op == OP_INDIRECT_INVOKE);
            if (x.load) begin
                x.npc = q.z_ptr;
                x.cyc = x.push ? `ABX_CYC_THREE : `ABX_CYC_TWO;
            end else if (tk) begin
                x.npc = q.pc + (q.next_two_word ? `ABX_SKIP_LONG : `ABX_SKIP_SHORT);
                x.cyc = q.next_two_word ? `ABX_CYC_THREE : `ABX_CYC_TWO;
            end
        end
        return x;
    endfunction

    function automatic abx_tb_exp_s ref_word(input abx_req_s q, input abx_tb_exp_s i,
                                             input logic add);
        abx_tb_exp_s x;
        logic [16:0] w;
        logic [15:0] pa;
        x = i;
        pa = {q.d_hi, q.d_val};
        w = add ? 17'(pa) + 17'(q.imm[KW-1:0]) : 17'(pa) - 17'(q.imm[KW-1:0]);
        x.sreg = q.sreg;
        x.grp = 2'h2;
        x.cyc = `ABX_CYC_TWO;
        x.pair = 1'b1;
        x.data = w[15:0];
        x.sreg[`ABX_FLAG_C] = w[16];
        x.sreg[`ABX_FLAG_V] = add ? !pa[15] && w[15] : pa[15] && !w[15];
        x.sreg[`ABX_FLAG_N] = w[15];
        x.sreg[`ABX_FLAG_Z] = (w[15:0] == 16'h0000);
        x.sreg[`ABX_FLAG_S] = w[15] ^ x.sreg[`ABX_FLAG_V];
        return x;
    endfunction

    // ********************************
    // Checks
    // ********************************
    task automatic cmp8(input logic [7:0] g, input logic [7:0] x);
        checked++;
        if (g !== x) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic cmp16(input logic [15:0] g, input logic [15:0] x);
        cmp8(g[15:8], x[15:8]);
        cmp8(g[7:0], x[7:0]);
    endtask

    task automatic close_out();
        $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (!rst_b) begin
            exp_q.delete();
            acc_q.delete();
        end else begin
            if (done && acc_q.size() == 0) begin
                cmp8({7'h00, done}, 8'h00);
            end else if (done) begin
                e = exp_q.pop_front();
                lat = 8'(cyc - acc_q.pop_front());
                cy = {6'h00, e.cyc};
                got = e.pair ? res.wr_data : {8'h00, res.wr_data[7:0]};
                if (!e.wro) begin
                    cmp8({7'h00, res.wr_en}, {7'h00, e.wr});
                end
                if (e.wr && (!e.wro || res.wr_en === 1'b1)) begin
                    cmp16(got, e.data);
                    cmp8({3'h0, res.wr_addr}, {3'h0, e.addr});
                end
                case (e.grp)
                    2'h0: begin
                        cmp8(res.sreg, e.sreg);
                        cmp8(lat, cy);
                    end
                    2'h1: begin
                        cmp8(res.sreg, e.sreg);
                        cmp8(lat, cy);
                    end
                    2'h2: begin
                        cmp8(res.sreg, e.sreg);
                        cmp8({lat[6:0], res.wr_pair}, {cy[6:0], e.pair});
                    end
                    default: begin
                        cmp8(res.sreg, e.sreg);
                        cmp8(lat, cy);
                        cmp16(res.next_pc, e.npc);
                        cmp8({7'h00, res.ret_push}, {7'h00, e.push});
                        cmp8({7'h00, res.pc_load}, {7'h00, e.load});
                    end
                endcase
                if (e.push) begin
                    cmp16(res.ret_addr, e.ret);
                end
            end
            if (req_valid && req_ready) begin
                acc_q.push_back(cyc);
            end
        end
    end

    // ********************************
    // Stimulus
    // ********************************
    task automatic issue(input abx_tb_row_s r);
        exp_q.push_back(r.exp);
        abx_fetch_model_inst.push(r.req);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while ((exp_q.size() > 0 || req_valid) && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 2000) begin
            mismatches++;
        end
        @(negedge clk);
    endtask

    task automatic chk_idle();
        cmp8({7'h00, req_ready}, 8'h01);
        cmp8({7'h00, done}, 8'h00);
        cmp8({7'h00, res === '0}, 8'h01);
    endtask

    initial begin
        rst_b = 1'b0;
        slow = 1'b0;
        mismatches = 0;
        checked = 0;
        cyc = 0;
        base[0] = '{OP_CARRY_SUM_REGS, 5'h10, 8'h3C, 8'h7F, 8'hC5, 8'h0F, 3'h2, 8'h08,
                    16'h0100, 16'h1234, 8'h21, 1'b0};
        base[1] = '{OP_CARRY_SUM_REGS, 5'h18, 8'h80, 8'h00, 8'h80, 8'h3F, 3'h7, 8'h00,
                    16'h7FFE, 16'h0FF0, 8'hDE, 1'b1};
        base[2] = '{OP_CARRY_SUM_REGS, 5'h1A, 8'hFF, 8'hFF, 8'h01, 8'h01, 3'h0, 8'hFF,
                    16'hFFFE, 16'h0002, 8'h01, 1'b0};
        for (int i = 0; i < 90; i++) begin
            rows[i].req = base[i / 30];
            rows[i].req.op = abx_op_e'(i % 30);
            rows[i].exp = ref_of(rows[i].req);
        end
        @(posedge clk);
        #1;
        chk_idle();
        @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        foreach (rows[i]) begin
            issue(rows[i]);
        end
        wait_idle();
        $display("Back-to-back table done");
        @(posedge clk);
        slow <= 1'b1;
        @(negedge clk);
        for (int i = 30; i < 60; i++) begin
            issue(rows[i]);
        end
        wait_idle();
        $display("Stalled table done");
        issue(rows[44]);
        repeat (2) @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        chk_idle();
        @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk_idle();
        @(negedge clk);
        issue(rows[51]);
        wait_idle();
        $display("Mid-run reset done");
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        cmp8(8'h00, 8'hFF);
        close_out();
    end
endmodule // tb_top
